// [hw/cebes_top.sv]
/*
  Per-bank ECC error status register with its companion mask register,
  reached through the card controller's memory-mapped register port.
  Assumes a simple single-cycle register port on CORE_CLK (address,
  read and write strobes, byte enables) and an ECC engine on the same
  clock that presents one bank result per strobe.
*/
// Contract
// - One 32-bit status word: eight banks, four flags each, bank 8 on top.
// - Low-bits-zero flag sets when the bank's bits 3:0 are all zero.
// - Uncorrectable flag sets when the bank's error cannot be corrected.
// - Single-bit flag sets when the bank shows exactly a one-bit error.
// - Code-error flag sets when the stored correction code itself is bad.
// - Flags reset to zero; writing one clears a flag, zero leaves it.
// - Offsets after the status word up to the window top are reserved.
// - Mask register, same layout; one enables a condition, zero disables.
`default_nettype none
`timescale 1ns/100ps

module cebes_top
  import cebes_pkg::*;
(
  input  wire logic                             CORE_CLK,     // Core clock.
  input  wire logic                             RST,          // Async reset.
  input  wire logic [cebes_pkg::ADDR_W-1:0]     REG_ADDR,     // Byte offset.
  input  wire logic                             REG_WR,       // Write strobe.
  input  wire logic                             REG_RD,       // Read strobe.
  input  wire logic [cebes_pkg::BE_W-1:0]       REG_BE,       // Byte enables.
  input  wire logic [cebes_pkg::DATA_W-1:0]     REG_WDATA,    // Write data.
  output var  logic [cebes_pkg::DATA_W-1:0]     REG_RDATA,    // Read data.
  output var  logic                             REG_ACK,      // Access done.
  input  wire logic                             ECC_VALID,    // Result strobe.
  input  wire logic [cebes_pkg::BANK_IDX_W-1:0] ECC_BANK,     // Bank index.
  input  wire logic [cebes_pkg::LOW_BITS_W-1:0] ECC_LOW_BITS, // Bits 3:0.
  input  wire logic                             ECC_UNCORR,   // Uncorrectable.
  input  wire logic                             ECC_SINGLE,   // One-bit error.
  input  wire logic                             ECC_CODE_ERR, // Code error.
  output var  logic [cebes_pkg::DATA_W-1:0]     STATUS_FLAGS  // Flag copy.
);

  import cebes_pkg::*;

  // Byte enable widened to a bit mask, used by both writable registers.
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Address decode, shared by the read and write paths.
  function automatic logic is_reg(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] mask_d;
  logic [DATA_W-1:0] raw_set;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              ack_q;
  logic              hit_status;
  logic              hit_mask;
  logic              hit_rsvd;

  // Classifies the current ECC result into per-bank set requests.
  cebes_bank_classify u_classify (
    .valid    (ECC_VALID),
    .bank     (ECC_BANK),
    .low_bits (ECC_LOW_BITS),
    .uncorr   (ECC_UNCORR),
    .single   (ECC_SINGLE),
    .code_err (ECC_CODE_ERR),
    .set_vec  (raw_set)
  );

  // Decode of the two live words; everything else in the window is dead.
  assign hit_status = is_reg(REG_ADDR, STATUS_OFS);
  assign hit_mask   = is_reg(REG_ADDR, MASK_OFS);
  assign wmask      = lane_mask(REG_BE);

  assign hit_rsvd = ((REG_ADDR >= RSV_A_LO) && (REG_ADDR <= RSV_A_HI)) ||
                    ((REG_ADDR >= RSV_B_LO) && (REG_ADDR <= RSV_B_HI));

  assign set_vec = raw_set & mask_q;

  assign clr_vec = (REG_WR && hit_status) ? (REG_WDATA & wmask) : '0;

  // Sets are ORed in after the clear, so an event racing a clear survives.
  always_comb
  begin
    status_d = (status_q & ~clr_vec) | set_vec;
  end

  // Mask write merges only the enabled byte lanes.
  always_comb
  begin
    mask_d = mask_q;
    if (REG_WR && hit_mask)
    begin
      mask_d = (mask_q & ~wmask) | (REG_WDATA & wmask);
    end
  end

  // Read mux. Reserved and unmapped offsets read zero and ignore writes.
  always_comb
  begin
    rdata_d = READ_ZERO;
    if (REG_RD && hit_status)
    begin
      rdata_d = status_q;
    end
    else if (REG_RD && hit_mask)
    begin
      rdata_d = mask_q;
    end
    else if (REG_RD && hit_rsvd)
    begin
      rdata_d = READ_ZERO;
    end
  end

  // Sticky status flags.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      status_q <= STATUS_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // Mask register; resets to all conditions disabled.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      mask_q <= MASK_RESET;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // Read data is registered so the port never sees a combinational path;
  // the price is one cycle of read latency.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_q <= READ_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Every access is acknowledged one cycle later, mapped or not.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= REG_RD | REG_WR;
    end
  end

  // Outputs straight from flip-flops.
  assign REG_RDATA    = rdata_q;
  assign REG_ACK      = ack_q;
  assign STATUS_FLAGS = status_q;

endmodule // cebes_top

`default_nettype wire

// [hw/cebes_pkg.sv]
/*
  Constants shared by the bank error status block: register offsets,
  field positions inside a bank nibble, reset values and widths.
  Assumes a byte-addressed register window of 256 bytes, 32-bit words.
*/
`default_nettype none

package cebes_pkg;

  // Register window geometry.
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned BE_W           = 4;

  // Bank layout: eight banks of four flags, bank 1 in the low nibble.
  localparam int unsigned NUM_BANKS      = 8;
  localparam int unsigned FLAGS_PER_BANK = 4;
  localparam int unsigned BANK_IDX_W     = 3;
  localparam int unsigned LOW_BITS_W     = 4;

  // Flag positions inside one bank nibble, high to low.
  localparam int unsigned FLD_LOW_ZERO   = 3;
  localparam int unsigned FLD_UNCORR     = 2;
  localparam int unsigned FLD_SINGLE     = 1;
  localparam int unsigned FLD_CODE_ERR   = 0;

  // Register offsets in the card controller register space.
  localparam logic [7:0] MASK_OFS        = 8'h64;
  localparam logic [7:0] STATUS_OFS      = 8'h80;
  localparam logic [7:0] RSV_A_LO        = 8'h84;
  localparam logic [7:0] RSV_A_HI        = 8'hbf;
  localparam logic [7:0] RSV_B_LO        = 8'hc0;
  localparam logic [7:0] RSV_B_HI        = 8'hff;

  // Reset values.
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

endpackage : cebes_pkg

`default_nettype wire

// [hw/cebes_bank_classify.sv]
/*
  Turns one ECC result for one bank into a 32-bit vector of set requests,
  one nibble per bank, only the addressed bank's nibble active.
  Assumes its inputs come from the ECC engine on the same clock and are
  only meaningful while the valid strobe is high.
*/
`default_nettype none
`timescale 1ns/100ps

module cebes_bank_classify
  import cebes_pkg::*;
(
  input  wire logic                             valid,    // Result strobe.
  input  wire logic [cebes_pkg::BANK_IDX_W-1:0] bank,     // Bank, 0 = bank 1.
  input  wire logic [cebes_pkg::LOW_BITS_W-1:0] low_bits, // Checked bits 3:0.
  input  wire logic                             uncorr,   // Not correctable.
  input  wire logic                             single,   // One-bit error.
  input  wire logic                             code_err, // Code itself bad.
  output wire logic [cebes_pkg::DATA_W-1:0]     set_vec   // Set requests.
);

  // Builds the flag nibble of one result in the documented order.
  function automatic logic [FLAGS_PER_BANK-1:0] nibble_of(
    input logic [LOW_BITS_W-1:0] bits,
    input logic                  unc,
    input logic                  one,
    input logic                  cod
  );
    logic [FLAGS_PER_BANK-1:0] n;
    n = '0;
    n[FLD_LOW_ZERO] = (bits == '0);
    n[FLD_UNCORR]   = unc;
    n[FLD_SINGLE]   = one;
    n[FLD_CODE_ERR] = cod;
    return n;
  endfunction

  logic [FLAGS_PER_BANK-1:0] nib;

  // The nibble is shared; only the addressed bank's lane passes it on.
  assign nib = nibble_of(low_bits, uncorr, single, code_err);

  // One lane per bank; bank 1 sits in bits 3:0, bank 8 in bits 31:28.
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_lane
    assign set_vec[b*FLAGS_PER_BANK +: FLAGS_PER_BANK] =
      (valid && (bank == BANK_IDX_W'(b))) ? nib : '0;
  end

endmodule // cebes_bank_classify

`default_nettype wire

// [bench/cebes_top_asserts.sv]
/*
  Port-level assertions for the bank error status block.
  Assumes one CORE_CLK domain and RST asynchronous, active high.
*/
`default_nettype none
`timescale 1ns/100ps

module cebes_top_asserts
  import cebes_pkg::*;
(
  input wire logic                             CORE_CLK,     // Clock.
  input wire logic                             RST,          // Reset.
  input wire logic [cebes_pkg::ADDR_W-1:0]     REG_ADDR,     // Offset.
  input wire logic                             REG_WR,       // Write.
  input wire logic                             REG_RD,       // Read.
  input wire logic [cebes_pkg::BE_W-1:0]       REG_BE,       // Enables.
  input wire logic [cebes_pkg::DATA_W-1:0]     REG_WDATA,    // Wdata.
  input wire logic [cebes_pkg::DATA_W-1:0]     REG_RDATA,    // Rdata.
  input wire logic                             REG_ACK,      // Ack.
  input wire logic                             ECC_VALID,    // Strobe.
  input wire logic [cebes_pkg::BANK_IDX_W-1:0] ECC_BANK,     // Bank.
  input wire logic [cebes_pkg::LOW_BITS_W-1:0] ECC_LOW_BITS, // Bits.
  input wire logic                             ECC_UNCORR,   // Uncorr.
  input wire logic                             ECC_SINGLE,   // Single.
  input wire logic                             ECC_CODE_ERR, // Code.
  input wire logic [cebes_pkg::DATA_W-1:0]     STATUS_FLAGS  // Flags.
);
  // One domain, so clock and reset are given once for all properties.
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Every access is answered exactly one cycle later, and only then.
  ack_follows_a: assert property ((REG_RD | REG_WR) |=> REG_ACK)
    else $error("access not acknowledged");
  ack_cause_a: assert property (REG_ACK |-> $past(REG_RD | REG_WR))
    else $error("acknowledge without access");
  rdata_idle_a: assert property (!REG_ACK |-> REG_RDATA == READ_ZERO)
    else $error("read data not zero outside a read");
  status_read_a: assert property (REG_RD && REG_ADDR == STATUS_OFS
    |=> REG_RDATA == $past(STATUS_FLAGS)) else $error("status read wrong");
  rsv_read_a: assert property (REG_RD && REG_ADDR >= RSV_A_LO
    |=> REG_RDATA == READ_ZERO) else $error("reserved read not zero");
  // A full clear without a new event must leave no written bit set.
  w1c_clear_a: assert property (REG_WR && REG_ADDR == STATUS_OFS
    && REG_BE == 4'hf && !ECC_VALID
    |=> (STATUS_FLAGS & $past(REG_WDATA)) == 32'h0)
    else $error("flag survived a clear");
  flag_sticky_a: assert property (!ECC_VALID && !REG_WR
    |=> $stable(STATUS_FLAGS)) else $error("flag changed without cause");
  // A result may raise flags only inside its own bank nibble.
  bank_nibble_a: assert property (ECC_VALID
    |=> (STATUS_FLAGS & ~$past(STATUS_FLAGS)
    & ~(32'hf << (4 * $past(ECC_BANK)))) == 32'h0)
    else $error("flag set outside addressed bank");

  cover property (REG_RD && REG_ADDR == STATUS_OFS && STATUS_FLAGS != 0);
  cover property (ECC_VALID && REG_WR && REG_ADDR == STATUS_OFS);
  cover property (REG_RD && REG_ADDR >= RSV_B_LO);
endmodule // cebes_top_asserts

bind cebes_top cebes_top_asserts chk_u (.*);

`default_nettype wire

// [bench/testbench.sv]
/*
  Self-checking bench for the bank error status block.
  Assumes the design's package and top module are compiled first.
*/
`default_nettype none
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module testbench;
  import cebes_pkg::*;
  logic        CORE_CLK, RST, REG_WR, REG_RD, REG_ACK, ECC_VALID;
  logic        ECC_UNCORR, ECC_SINGLE, ECC_CODE_ERR;
  logic [7:0]  REG_ADDR;
  logic [3:0]  REG_BE, ECC_LOW_BITS;
  logic [2:0]  ECC_BANK;
  logic [31:0] REG_WDATA, REG_RDATA, STATUS_FLAGS, seed, stat, mask, q;
  int          miscompares, checks;
  // Reserved offsets probed by hand: both ends of each reserved range.
  logic [7:0]  rsv [4] = '{8'h84, 8'hbc, 8'hc0, 8'hfc};

  cebes_top dut_u (.*);

  // Free-running 100 MHz clock.
  always #5 CORE_CLK = ~CORE_CLK;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Result word r: bits 3:0 checked bits, 4 uncorr, 5 single, 6 code, 9:7 bank.
  function automatic logic [31:0] exp_set(input logic [31:0] r, m);
    logic [31:0] v;
    v = {28'h0, r[3:0] == 4'h0, r[4], r[5], r[6]} << (4 * r[9:7]);
    return v & m;
  endfunction

  function automatic logic [31:0] bytes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // One cycle of stimulus; the model applies a clear before a set.
  task automatic cyc(input logic v, w, rd, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d, r);
    logic [31:0] e;
    e = (a == STATUS_OFS) ? stat : (a == MASK_OFS) ? mask : READ_ZERO;
    @(negedge CORE_CLK);
    {ECC_VALID, REG_WR, REG_RD} = {v, w, rd};
    {REG_ADDR, REG_BE, REG_WDATA} = {a, be, d};
    {ECC_BANK, ECC_CODE_ERR, ECC_SINGLE, ECC_UNCORR, ECC_LOW_BITS} = r[9:0];
    if (w && a == STATUS_OFS)
      stat = stat & ~(d & bytes(be));
    if (v)
      stat = stat | exp_set(r, mask);
    @(negedge CORE_CLK);
    q = REG_RDATA;
    {ECC_VALID, REG_WR, REG_RD} = 3'b000;
    if (w && a == MASK_OFS)
      mask = (mask & ~bytes(be)) | (d & bytes(be));
    `CHK(REG_ACK, w | rd)
    `CHK(STATUS_FLAGS, stat)
    if (rd)
      `CHK(q, e)
  endtask

  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence: reset values, masking, every bank, then random traffic.
  initial
  begin
    {CORE_CLK, RST, REG_WR, REG_RD, ECC_VALID} = 5'b01000;
    {REG_ADDR, REG_BE, REG_WDATA, ECC_BANK, ECC_LOW_BITS} = '0;
    {ECC_UNCORR, ECC_SINGLE, ECC_CODE_ERR} = 3'b000;
    {seed, stat, mask, miscompares, checks} = {32'h5c036bb8, 128'h0};
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST = 1'b0;
    cyc(0, 0, 1, STATUS_OFS, 4'h0, 32'h0, 32'h0);
    cyc(0, 0, 1, MASK_OFS, 4'h0, 32'h0, 32'h0);
    // A zero mask must drop every condition for good.
    cyc(1, 0, 0, 8'h00, 4'h0, 32'h0, 32'h070);
    cyc(0, 1, 1, MASK_OFS, 4'hf, 32'hffff_ffff, 32'h0);
    for (int b = 0; b < 8; b++)
      cyc(1, 0, 1, STATUS_OFS, 4'h0, 32'h0, {b[2:0], 7'h70});
    // Clear everything while bank 8 reports in the same cycle.
    cyc(1, 1, 1, STATUS_OFS, 4'hf, 32'hffff_ffff, 32'h3f0);
    foreach (rsv[i])
    begin
      cyc(0, 1, 0, rsv[i], 4'hf, '1, 32'h0);
      cyc(0, 0, 1, rsv[i], 4'h0, '0, 32'h0);
    end
    // Random mix of results, clears, mask writes and reserved accesses.
    for (int i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      cyc(seed[0], seed[1], seed[2], seed[3] ? STATUS_OFS : seed[8] ?
          MASK_OFS : {2'b11, seed[13:10], 2'b00}, seed[7:4], lfsr(seed),
          {seed[31:26], seed[9] ? 4'h0 : seed[17:14]});
    end
    finish_test;
  end

  // A hang is cut short well beyond the roughly 660 cycles the run needs.
  initial
  begin
    repeat (5000) @(posedge CORE_CLK);
    miscompares++;
    finish_test;
  end
endmodule // testbench

`default_nettype wire
